// >>> verilog/maexe_cfg.svh
`ifndef MAEXE_CFG_SVH
`define MAEXE_CFG_SVH

// Register byte offsets on the APB side
`define MAEXE_OFS_WREG 12'h000
`define MAEXE_OFS_STAT 12'h004
`define MAEXE_OFS_SEQ 12'h008

// Status register field positions
`define MAEXE_STAT_C 0
`define MAEXE_STAT_DC 1
`define MAEXE_STAT_Z 2

// Reset values
`define MAEXE_RST_WREG 8'h00
`define MAEXE_RST_FLAG 1'b0

// Widths and cycle figures of the datapath
`define MAEXE_PC_W 15
`define MAEXE_FADDR_MAX 7'h7f
`define MAEXE_TWO_CYCLE_EXTRA 1

`endif

// >>> verilog/maexe_pkg.sv
package maexe_pkg;

  // Operations this datapath executes; anything else is ignored
  typedef enum logic [2:0] {
    MAEXE_OP_NONE = 3'h0,
    MAEXE_OP_ADD = 3'h1,
    MAEXE_OP_ADDC = 3'h2,
    MAEXE_OP_ASR = 3'h3,
    MAEXE_OP_BCLR = 3'h4,
    MAEXE_OP_BTSZ = 3'h5,
    MAEXE_OP_BRA = 3'h6
  } maexe_op_e;

  // Gray coded: run then the forced no-operation cycle
  typedef enum logic [1:0] {
    MAEXE_ST_RUN = 2'b00,
    MAEXE_ST_NOP = 2'b01
  } maexe_st_e;

  // Decoded instruction from the sequencer
  typedef struct packed {
    maexe_op_e op;
    logic [6:0] faddr;
    logic dest;
    logic [2:0] bitsel;
    logic [8:0] offs;
  } maexe_instr_s;

  // Register file write request
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } maexe_fwr_s;

  // Whole state of the executor
  typedef struct packed {
    maexe_st_e st;
    logic [7:0] w;
    logic c;
    logic dc;
    logic z;
    maexe_fwr_s fwr;
    logic pcld;
    logic [14:0] pct;
    logic disc;
    logic busy;
    logic rdy;
    logic err;
    logic [31:0] rd;
  } maexe_state_s;

endpackage

// >>> verilog/maexe_top.sv
// Notes on behaviour
// RULE1 - Add sums working register and file register (address 0..127), updating carry, digit carry and zero.
// RULE2 - Destination bit 0 sends the result to the working register, 1 back to the file register.
// RULE3 - Arithmetic right shift keeps bit 7, moves bits 7:1 down, old bit 0 to carry, touches only carry and zero.
// RULE4 - Add with carry sums working register, file register and carry into the chosen destination, updating three flags.
// RULE5 - Bit clear zeroes the chosen bit 0..7 of the file register, keeps the rest, and leaves all flags.
// RULE6 - Test-bit-skip-if-zero runs the next instruction when the bit is one, else discards it for a no-operation, two cycles.
// RULE7 - Relative branch loads the program counter with the incremented counter plus a signed 9-bit offset, no flags.
// RULE8 - Relative branch always takes two cycles since the fetched next instruction is dropped.
// RULE9 - A program counter change or a true test adds a second cycle acting as a no-operation.
// RULE10 - Digit carry is the carry out of bit 3 into bit 4, and zero is set for an all-zero result.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "maexe_cfg.svh"

module maexe_top
  import maexe_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Instruction issue from the sequencer
  input wire logic issue_valid_in,
  input wire maexe_instr_s instr_in,
  input wire logic [14:0] pc_in,
  input wire logic [7:0] file_data_in,
  // Results toward the register file and sequencer
  output maexe_fwr_s file_wr_out,
  output logic pc_load_out,
  output logic [14:0] pc_target_out,
  output logic discard_out,
  output logic busy_out,
  output logic [7:0] wreg_out,
  output logic [2:0] status_out,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);

  maexe_state_s s_r;
  maexe_state_s s_nxt;

  // Arithmetic helpers
  logic cin;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] res;
  logic [7:0] mask;
  logic [14:0] sext;
  logic take;
  logic acc;
  logic hit;

  // Operation decode of the issued word
  logic op_add;
  logic op_asr;
  logic op_bra;
  logic to_dest;
  logic skip_hit;
  logic two_cycle;

  // Result and flags of each datapath arm
  logic [7:0] add_res;
  logic add_c;
  logic add_dc;
  logic add_z;
  logic [7:0] asr_res;
  logic asr_c;
  logic asr_z;
  logic [7:0] bclr_res;
  logic bit_set;
  logic [14:0] pc_next;
  logic [14:0] bra_tgt;

  // Register bus decode
  logic sel_wreg;
  logic sel_stat;
  logic sel_seq;
  logic wr_ok;

  // Carry in only for the add-with-carry form
  always_comb begin
    cin = (instr_in.op == MAEXE_OP_ADDC) ? s_r.c : 1'b0;
    // RULE1 add path
    sum = {1'b0, s_r.w} + {1'b0, file_data_in} + {8'h00, cin};
    // RULE10 nibble carry
    nib = {1'b0, s_r.w[3:0]} + {1'b0, file_data_in[3:0]} + {4'h0, cin};
    // Mask of the tested or cleared bit
    mask = 8'h01 << instr_in.bitsel;
    // Offset sign carried up to the counter width
    sext = {{6{instr_in.offs[8]}}, instr_in.offs};
  end

  // Decode of the issued operation
  always_comb begin
    // Both add forms share one adder, only the carry in differs
    op_add = (instr_in.op == MAEXE_OP_ADD) || (instr_in.op == MAEXE_OP_ADDC);
    op_asr = (instr_in.op == MAEXE_OP_ASR);
    op_bra = (instr_in.op == MAEXE_OP_BRA);
    // RULE2 bit ops and the branch ignore the destination bit
    to_dest = (op_add || op_asr) && instr_in.dest;
    // RULE6 a clear tested bit discards the next word
    skip_hit = (instr_in.op == MAEXE_OP_BTSZ) && !bit_set;
    // RULE9 a counter change or a true test costs a second cycle
    two_cycle = op_bra || skip_hit;
  end

  // Arithmetic arms; the state update below only picks among them
  always_comb begin
    // RULE1 RULE4 sum and carry out of bit 7
    add_res = sum[7:0];
    add_c = sum[8];
    // RULE10 nibble carry and zero detect
    add_dc = nib[4];
    add_z = (sum[7:0] == 8'h00);
    // RULE3 sign bit kept, bit 0 into carry
    asr_res = {file_data_in[7], file_data_in[7:1]};
    asr_c = file_data_in[0];
    asr_z = (asr_res == 8'h00);
  end

  // Bit and branch arms
  always_comb begin
    // RULE5 one bit forced low, the rest kept
    bclr_res = file_data_in & ~mask;
    bit_set = ((file_data_in & mask) != 8'h00);
    // RULE7 counter stepped one past the branch first; the sum wraps at 15 bits
    pc_next = pc_in + 15'h0001;
    bra_tgt = pc_next + sext;
  end

  // An instruction is only taken outside the no-operation cycle
  assign take = issue_valid_in && (s_r.st == MAEXE_ST_RUN);

  // APB access phase, answered one cycle later with pready
  assign acc = psel_in && penable_in;

  // Address decode; one word per register, so the upper bits must match too
  assign sel_wreg = (paddr_in == `MAEXE_OFS_WREG);
  assign sel_stat = (paddr_in == `MAEXE_OFS_STAT);
  assign sel_seq = (paddr_in == `MAEXE_OFS_SEQ);
  // A write lands on the edge where pready is seen high, unless it was refused
  assign wr_ok = acc && s_r.rdy && pwrite_in && !s_r.err;

  always_comb begin
    // Everything holds, and the one-cycle pulses drop unless set below
    s_nxt = s_r;
    s_nxt.fwr.we = 1'b0;
    s_nxt.pcld = 1'b0;
    s_nxt.disc = 1'b0;
    s_nxt.rdy = 1'b0;
    s_nxt.err = 1'b0;
    // Scratch values for this cycle
    res = 8'h00;
    hit = 1'b1;

    // Bus read data is captured in the wait cycle, so one wait state always
    if (acc && !s_r.rdy) begin
      s_nxt.rdy = 1'b1;
      s_nxt.rd = 32'h0000_0000;
      if (sel_wreg) begin
        s_nxt.rd[7:0] = s_r.w;
      end else if (sel_stat) begin
        s_nxt.rd[`MAEXE_STAT_C] = s_r.c;
        s_nxt.rd[`MAEXE_STAT_DC] = s_r.dc;
        s_nxt.rd[`MAEXE_STAT_Z] = s_r.z;
      end else if (sel_seq) begin
        // Sequencer state is read only
        s_nxt.rd[0] = s_r.busy;
      end else begin
        // Unmapped word answers with an error and zero data
        hit = 1'b0;
      end
      s_nxt.err = !hit;
    end

    // Writes to the read-only or unmapped words are dropped
    if (wr_ok) begin
      if (sel_wreg) begin
        s_nxt.w = pwdata_in[7:0];
      end else if (sel_stat) begin
        s_nxt.c = pwdata_in[`MAEXE_STAT_C];
        s_nxt.dc = pwdata_in[`MAEXE_STAT_DC];
        s_nxt.z = pwdata_in[`MAEXE_STAT_Z];
      end
    end

    // Instruction execution; it overrides a same-cycle bus write
    case (s_r.st)
      MAEXE_ST_NOP: begin
        // An issue seen here is ignored, as the sequencer drops that word
        // RULE9 second cycle idles
        s_nxt.st = MAEXE_ST_RUN;
        s_nxt.busy = 1'b0;
      end
      MAEXE_ST_RUN: begin
        if (take) begin
          case (instr_in.op)
            MAEXE_OP_ADD, MAEXE_OP_ADDC: begin
              // RULE1 RULE4 flags from sum
              res = add_res;
              s_nxt.c = add_c;
              // RULE10 digit carry and zero
              s_nxt.dc = add_dc;
              s_nxt.z = add_z;
            end
            MAEXE_OP_ASR: begin
              // RULE3 sign kept, bit 0 to carry, digit carry left alone
              res = asr_res;
              s_nxt.c = asr_c;
              s_nxt.z = asr_z;
            end
            MAEXE_OP_BCLR: begin
              // RULE5 clear one bit, no flags
              s_nxt.fwr.we = 1'b1;
              s_nxt.fwr.addr = instr_in.faddr;
              // Written back even when the bit was already clear
              s_nxt.fwr.data = bclr_res;
            end
            MAEXE_OP_BTSZ: begin
              // RULE6 test only; the skip itself is handled below
              res = 8'h00;
            end
            MAEXE_OP_BRA: begin
              // RULE7 incremented counter plus offset
              s_nxt.pct = bra_tgt;
              // Target stands after the pulse until the next branch
              s_nxt.pcld = 1'b1;
            end
            default: res = 8'h00;
          endcase

          // RULE8 fetched word dropped, then one idle cycle
          if (two_cycle) begin
            s_nxt.disc = 1'b1;
            // Busy also refuses the next issue for that cycle
            s_nxt.busy = 1'b1;
            s_nxt.st = MAEXE_ST_NOP;
          end

          // RULE2 destination select
          if (to_dest) begin
            s_nxt.fwr.we = 1'b1;
            s_nxt.fwr.addr = instr_in.faddr;
            s_nxt.fwr.data = res;
          end else if (op_add || op_asr) begin
            // Bit ops and the branch leave the working register alone
            s_nxt.w = res;
          end
        end
      end
      default: begin
        // Unused code recovers to run
        s_nxt.st = MAEXE_ST_RUN;
        s_nxt.busy = 1'b0;
      end
    endcase
  end

  // Single state register; reset loads constants only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r.st <= MAEXE_ST_RUN;
      s_r.fwr <= '0;
      s_r.pcld <= 1'b0;
      s_r.pct <= 15'h0000;
      s_r.disc <= 1'b0;
      s_r.busy <= 1'b0;
      s_r.rdy <= 1'b0;
      s_r.err <= 1'b0;
      s_r.rd <= 32'h0000_0000;
      // Working register and flags restart cleared
      s_r.w <= `MAEXE_RST_WREG;
      s_r.c <= `MAEXE_RST_FLAG;
      s_r.dc <= `MAEXE_RST_FLAG;
      s_r.z <= `MAEXE_RST_FLAG;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Instruction side outputs come straight from the state register
  assign file_wr_out = s_r.fwr;
  assign pc_load_out = s_r.pcld;
  assign pc_target_out = s_r.pct;
  assign discard_out = s_r.disc;
  assign busy_out = s_r.busy;
  assign wreg_out = s_r.w;
  assign status_out = {s_r.z, s_r.dc, s_r.c};

  // Bus answer, registered so pready never follows psel within a cycle
  assign prdata_out = s_r.rd;
  assign pready_out = s_r.rdy;
  assign pslverr_out = s_r.err;

endmodule

`default_nettype wire

// >>> sim/maexe_file_model.sv
`timescale 1ns/10ps
`default_nettype none

module maexe_file_model
  import maexe_pkg::*;
(
  input wire logic clk_in,
  input wire maexe_instr_s instr_in,
  input wire maexe_fwr_s file_wr_in,
  output logic [7:0] file_data_out
);
  logic [7:0] mem [128];
  // Read is combinational because the executor samples it with the issue
  assign file_data_out = mem[instr_in.faddr];
  // Plain always so the bench may preload cells at time zero
  always @(posedge clk_in) begin
    if (file_wr_in.we) begin
      mem[file_wr_in.addr] <= file_wr_in.data;
    end
  end
endmodule

`default_nettype wire

// >>> sim/maexe_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module maexe_monitor
  import maexe_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic issue_valid_in,
  input wire maexe_instr_s instr_in,
  input wire logic [14:0] pc_in,
  input wire logic [7:0] file_data_in,
  input wire maexe_fwr_s file_wr_out,
  input wire logic pc_load_out,
  input wire logic [14:0] pc_target_out,
  input wire logic discard_out,
  input wire logic busy_out,
  input wire logic [7:0] wreg_out,
  input wire logic [2:0] status_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic tk;
  logic cin;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [10:0] addx;
  logic [10:0] asrx;
  maexe_op_e op;
  // Expected results worked out from the operands at the issue edge
  assign op = instr_in.op;
  assign tk = issue_valid_in && !busy_out;
  assign cin = op == MAEXE_OP_ADDC && status_out[0];
  assign sum = wreg_out + file_data_in + cin;
  assign nib = wreg_out[3:0] + file_data_in[3:0] + cin;
  assign addx = {sum[7:0] == 8'h00, nib[4], sum};
  assign asrx = {file_data_in[7], file_data_in[7:1], file_data_in[7:1] == 7'h00,
    status_out[1], file_data_in[0]};
  // The forced no-operation slot after a branch or a taken skip
  sequence s_nop_slot;
    busy_out && discard_out ##1 !busy_out;
  endsequence
  a_branch_target: assert property (tk && op == MAEXE_OP_BRA |=> pc_load_out &&
    pc_target_out == 15'($past(pc_in) + 15'h1 + 15'($signed($past(instr_in.offs))))
    && $stable(status_out)) else $error("branch target");
  a_branch_slot: assert property (tk && op == MAEXE_OP_BRA |=> s_nop_slot)
    else $error("branch slot");
  a_skip_zero: assert property (tk && op == MAEXE_OP_BTSZ &&
    !file_data_in[instr_in.bitsel] |=> s_nop_slot) else $error("skip slot");
  a_skip_one: assert property (tk && op == MAEXE_OP_BTSZ &&
    file_data_in[instr_in.bitsel] |=> !discard_out && !busy_out && $stable(status_out))
    else $error("no skip");
  a_add_file: assert property (tk && (op == MAEXE_OP_ADD || op == MAEXE_OP_ADDC) &&
    instr_in.dest |=> file_wr_out.we && {status_out, file_wr_out.data} == $past(addx))
    else $error("add to file");
  a_add_wreg: assert property (tk && (op == MAEXE_OP_ADD || op == MAEXE_OP_ADDC) &&
    !instr_in.dest |=> !file_wr_out.we && {status_out, wreg_out} == $past(addx))
    else $error("add to wreg");
  a_shift_wreg: assert property (tk && op == MAEXE_OP_ASR && !instr_in.dest
    |=> {wreg_out, status_out} == $past(asrx)) else $error("shift");
  a_clear_bit: assert property (tk && op == MAEXE_OP_BCLR |=> file_wr_out.we &&
    file_wr_out.data == ($past(file_data_in) & ~(8'h01 << $past(instr_in.bitsel)))
    && $stable(status_out)) else $error("bit clear");
endmodule

bind maexe_top maexe_monitor u_mon (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .issue_valid_in(issue_valid_in), .instr_in(instr_in), .pc_in(pc_in),
  .file_data_in(file_data_in), .file_wr_out(file_wr_out), .pc_load_out(pc_load_out),
  .pc_target_out(pc_target_out), .discard_out(discard_out), .busy_out(busy_out),
  .wreg_out(wreg_out), .status_out(status_out));

`default_nettype wire

// >>> sim/mcu_arith_bit_branch_exec_test.sv
`timescale 1ns/10ps
`default_nettype none

module mcu_arith_bit_branch_exec_test
  import maexe_pkg::*;
;
  logic clk_in = 0;
  logic rst_n_in = 0;
  logic iv = 0;
  logic psel = 0;
  logic pen = 0;
  logic pwr = 0;
  maexe_instr_s ins = '0;
  logic [14:0] pc = '0;
  logic [11:0] pa = '0;
  logic [31:0] pwd = '0;
  logic [31:0] q, prd;
  logic e, pcl, disc, busy, prdy, perr;
  maexe_fwr_s fwr;
  logic [7:0] fd, wreg;
  logic [2:0] st;
  logic [14:0] pct;
  int fail_count = 0;
  int samples_checked = 0;
  // Free running 100 MHz clock
  always #5 clk_in = ~clk_in;
  maexe_top u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .issue_valid_in(iv),
    .instr_in(ins), .pc_in(pc), .file_data_in(fd), .file_wr_out(fwr), .pc_load_out(pcl),
    .pc_target_out(pct), .discard_out(disc), .busy_out(busy), .wreg_out(wreg),
    .status_out(st), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
    .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr));
  maexe_file_model u_file (.clk_in(clk_in), .instr_in(ins), .file_wr_in(fwr),
    .file_data_out(fd));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // Request held until pready is sampled high; the watchdog bounds the wait
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_in);
    pen <= 1;
    do @(posedge clk_in); while (prdy !== 1'b1);
    q = prd;
    e = perr;
    psel <= 0;
    pen <= 0;
  endtask
  // Issue one instruction, then look just after the answer edge
  task run(input maexe_op_e op, input logic [6:0] fa, input logic d,
    input logic [2:0] b, input logic [8:0] k, input logic [14:0] p);
    @(posedge clk_in);
    iv <= 1;
    ins <= '{op, fa, d, b, k};
    pc <= p;
    @(posedge clk_in);
    iv <= 0;
    #1;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog well beyond the few dozen cycles the sequence needs
  initial begin
    #20000;
    fail_count++;
    complete_run;
  end
  initial begin
    u_file.mem[5] = 8'hc4;
    u_file.mem[6] = 8'h01;
    u_file.mem[7] = 8'h81;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1;
    apb(0, 12'h000, 0);
    chk(q, 0);
    apb(1, 12'h000, 32'h3c);
    apb(0, 12'h000, 0);
    chk(q, 32'h3c);
    apb(0, 12'h010, 0);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    run(MAEXE_OP_ADD, 5, 1, 0, 0, 0);
    chk({fwr, st}, {1'b1, 7'h05, 8'h00, 3'b111});
    run(MAEXE_OP_ADDC, 6, 0, 0, 0, 0);
    chk({fwr.we, wreg, st}, {1'b0, 8'h3e, 3'b000});
    run(MAEXE_OP_ASR, 7, 0, 0, 0, 0);
    chk({wreg, st}, {8'hc0, 3'b001});
    run(MAEXE_OP_BCLR, 7, 0, 7, 0, 0);
    chk({fwr, st}, {1'b1, 7'h07, 8'h01, 3'b001});
    run(MAEXE_OP_BTSZ, 7, 0, 1, 0, 0);
    chk({busy, disc}, 2'b11);
    run(MAEXE_OP_BTSZ, 7, 0, 0, 0, 0);
    chk({busy, disc, st}, 5'b00001);
    run(MAEXE_OP_BRA, 0, 0, 0, 9'h100, 15'h0100);
    chk({pcl, busy, disc, pct, st}, {3'b111, 15'h0001, 3'b001});
    @(posedge clk_in);
    #1;
    chk({pcl, busy}, 0);
    run(MAEXE_OP_BRA, 0, 0, 0, 9'h0ff, 15'h7fff);
    chk({pcl, pct}, {1'b1, 15'h00ff});
    complete_run;
  end
endmodule

`default_nettype wire
